/* File: common/arc_pkg.sv */
// Package for the abstract register-access command block.
package arc_pkg;

  // ==========================================================================
  // Register map (Wishbone byte addresses)
  localparam logic [7:0] ARC_ADR_CMD = 8'h00;
  localparam logic [7:0] ARC_ADR_STATUS = 8'h04;
  localparam logic [7:0] ARC_ADR_DATA0 = 8'h10;
  localparam logic [7:0] ARC_ADR_DATA1 = 8'h14;
  localparam logic [7:0] ARC_ADR_DATA2 = 8'h18;
  localparam logic [7:0] ARC_ADR_DATA3 = 8'h1c;
  localparam int ARC_NDATA = 4;

  // ==========================================================================
  // Command word fields
  localparam int ARC_TYPE_LSB = 24;
  localparam int ARC_ZERO_BIT = 23;
  localparam int ARC_SIZE_LSB = 20;
  localparam int ARC_INC_BIT = 19;
  localparam int ARC_PEXEC_BIT = 18;
  localparam int ARC_XFER_BIT = 17;
  localparam int ARC_WRITE_BIT = 16;
  localparam logic [7:0] ARC_TYPE_REG = 8'h00;

  localparam logic [2:0] ARC_SIZE_32 = 3'h2;
  localparam logic [2:0] ARC_SIZE_64 = 3'h3;
  localparam logic [2:0] ARC_SIZE_128 = 3'h4;

  // Register number groups.
  localparam logic [15:0] ARC_CSR_LAST = 16'h0fff;
  localparam logic [15:0] ARC_GPR_FIRST = 16'h1000;
  localparam logic [15:0] ARC_GPR_LAST = 16'h101f;
  localparam logic [15:0] ARC_FPR_FIRST = 16'h1020;
  localparam logic [15:0] ARC_FPR_LAST = 16'h103f;

  // Error codes.
  localparam logic [2:0] ARC_ERR_NONE = 3'h0;
  localparam logic [2:0] ARC_ERR_BUSY = 3'h1;
  localparam logic [2:0] ARC_ERR_NOTSUP = 3'h2;
  localparam logic [2:0] ARC_ERR_EXCEPT = 3'h3;

  // Status register layout.
  localparam int ARC_ST_BUSY_BIT = 12;
  localparam int ARC_ST_ERR_LSB = 8;

  typedef enum logic [2:0] {
    ARC_IDLE,
    ARC_XFER,
    ARC_XWAIT,
    ARC_EXEC,
    ARC_EWAIT
  } arc_state_t;

  // Request to the hart's register port.
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] regno;
    logic [63:0] wdata;
  } arc_hreq_t;

  // Answer from the hart's register port.
  typedef struct packed {
    logic ack;
    logic err;
    logic [63:0] rdata;
  } arc_hrsp_t;

endpackage

/* File: design/arc_top.sv */
// Abstract register-access command engine with a Wishbone register file.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// R1: Type zero selects register access decoding.
// R2: Transfer read copies register into first argument.
// R3: Transfer write copies first argument into register.
// R4: No transfer means size, regno ignored.
// R5: Order transfer, increment, execute; failure skips.
// R6: Upcoming failures may abort command early.
// R7: Missing register reports exception code.
// R8: GPR access while halted always works.
// R9: Size 2,3,4 select 32,64,128 bits.
// R10: Size wider than register fails.
// R11: Size sets number of argument words.
// R12: Auto-increment adds one after success.
// R13: Increment also applies without transfer.
// R14: Post-execute runs program buffer once.
// R15: Register number groups CSR, GPR, FPR.
// R16: PC alias via debug PC CSR.
// R17: Only first argument words change, reads only.
// R18: Debugger makes registers accessible itself.
// R19: Whole groups accessible when any is.
// R20: Core debug CSRs reachable when CSRs are.
// R21: Unsupported options give not-supported code.
// R22: Results land before busy clears, LSW low.
// R23: Command while busy records busy error.
// R24: Busy spans acceptance to last step.
// R25: Success leaves error field unchanged.
module arc_top
  import arc_pkg::*;
#(
  parameter logic [15:0] PROGBUF_WORDS = 16'h0002,
  parameter logic HAS_FPR = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hart_halted_i,
  output arc_hreq_t hreq_o,
  input wire arc_hrsp_t hrsp_i,
  output logic exec_req_o,
  input wire logic exec_done_i,
  input wire logic exec_err_i
);

  // ==========================================================================
  // State
  typedef struct packed {
    arc_state_t st;
    logic [31:0] cmd;
    logic [31:0] data0;
    logic [31:0] data1;
    logic [31:0] data2;
    logic [31:0] data3;
    logic [2:0] err;
    logic busy;
    logic ack;
    logic [31:0] rdat;
    arc_hreq_t hreq;
    logic exec;
    logic halted_m;
    logic halted;
  } arc_reg_t;

  arc_reg_t s_q;
  arc_reg_t s_d;

  // Byte-lane merge for Wishbone writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register existence: GPRs always, FPRs optionally, CSR group not implemented.
  // R15: group number ranges
  // R19: whole groups accessible
  // R20: no CSR group, none owed
  function automatic logic reg_exists(input logic [15:0] n);
    return (n >= ARC_GPR_FIRST && n <= ARC_GPR_LAST) ||
           (HAS_FPR && n >= ARC_FPR_FIRST && n <= ARC_FPR_LAST);
  endfunction

  logic acc;
  logic [7:0] ctype;
  logic [2:0] csize;
  logic cinc;
  logic cpexec;
  logic cxfer;
  logic cwrite;
  logic [15:0] cregno;
  logic [2:0] fail;
  logic cmd_wr;

  assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign ctype = s_q.cmd[ARC_TYPE_LSB +: 8];
  assign csize = s_q.cmd[ARC_SIZE_LSB +: 3];
  assign cinc = s_q.cmd[ARC_INC_BIT];
  assign cpexec = s_q.cmd[ARC_PEXEC_BIT];
  assign cxfer = s_q.cmd[ARC_XFER_BIT];
  assign cwrite = s_q.cmd[ARC_WRITE_BIT];
  assign cregno = s_q.cmd[15:0];
  assign cmd_wr = acc && wb_we_i && wb_adr_i == ARC_ADR_CMD;

  // ==========================================================================
  // Early failure check, before any step runs
  always_comb begin
    fail = ARC_ERR_NONE;
    // R1: only type zero is understood
    if (ctype != ARC_TYPE_REG || s_q.cmd[ARC_ZERO_BIT]) begin
      // R21: unsupported type or must-be-zero bit
      fail = ARC_ERR_NOTSUP;
    end else if (cpexec && PROGBUF_WORDS == 16'h0000) begin
      // R14: post-execute needs a program buffer
      fail = ARC_ERR_NOTSUP;
    // R4: size and regno only matter with transfer
    end else if (cxfer) begin
      // R9: sizes 32 and 64 bits supported, 128 too wide
      if (csize != ARC_SIZE_32 && csize != ARC_SIZE_64) begin
        // R10: wider than the 64-bit registers
        fail = (csize == ARC_SIZE_128) ? ARC_ERR_EXCEPT : ARC_ERR_NOTSUP;
      // R8: accesses go only to a halted hart
      // R16: no running access, no alias
      end else if (!s_q.halted) begin
        fail = ARC_ERR_NOTSUP;
      end else if (!reg_exists(cregno)) begin
        // R7: nonexistent register is an exception
        fail = ARC_ERR_EXCEPT;
      end
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.halted_m = hart_halted_i;
    s_d.halted = s_q.halted_m;
    s_d.hreq.req = 1'b0;
    s_d.exec = 1'b0;

    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        ARC_ADR_CMD: s_d.rdat = s_q.cmd;
        ARC_ADR_STATUS: begin
          s_d.rdat = 32'h0000_0000;
          s_d.rdat[ARC_ST_BUSY_BIT] = s_q.busy;
          s_d.rdat[ARC_ST_ERR_LSB +: 3] = s_q.err;
        end
        ARC_ADR_DATA0: s_d.rdat = s_q.data0;
        ARC_ADR_DATA1: s_d.rdat = s_q.data1;
        ARC_ADR_DATA2: s_d.rdat = s_q.data2;
        ARC_ADR_DATA3: s_d.rdat = s_q.data3;
        default: s_d.rdat = 32'h0000_0000;
      endcase
    end

    if (acc && wb_we_i) begin
      case (wb_adr_i)
        ARC_ADR_CMD: begin
          if (s_q.busy) begin
            // R23: command while busy flags busy, running one goes on
            s_d.err = ARC_ERR_BUSY;
          end else if (s_q.err == ARC_ERR_NONE) begin
            // R24: busy raised on acceptance
            s_d.cmd = merge(s_q.cmd, wb_dat_i, wb_sel_i);
            s_d.busy = 1'b1;
            s_d.st = ARC_XFER;
          end
        end
        ARC_ADR_STATUS: begin
          // Writing ones clears the error field.
          if (wb_sel_i[1]) begin
            s_d.err = s_q.err & ~wb_dat_i[ARC_ST_ERR_LSB +: 3];
          end
        end
        ARC_ADR_DATA0: if (!s_q.busy) s_d.data0 = merge(s_q.data0, wb_dat_i, wb_sel_i);
        ARC_ADR_DATA1: if (!s_q.busy) s_d.data1 = merge(s_q.data1, wb_dat_i, wb_sel_i);
        ARC_ADR_DATA2: if (!s_q.busy) s_d.data2 = merge(s_q.data2, wb_dat_i, wb_sel_i);
        ARC_ADR_DATA3: if (!s_q.busy) s_d.data3 = merge(s_q.data3, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end

    case (s_q.st)
      ARC_IDLE: ;
      ARC_XFER: begin
        // R5: fixed step order, failure ends the command
        // R6: command-field failures found before the first step, hart and program-buffer errors later
        if (fail != ARC_ERR_NONE) begin
          if (s_d.err == ARC_ERR_NONE) s_d.err = fail;
          s_d.busy = 1'b0;
          s_d.st = ARC_IDLE;
        end else if (cxfer) begin
          // R2 R3: issue the hart register transfer
          s_d.hreq.req = 1'b1;
          s_d.hreq.we = cwrite;
          s_d.hreq.regno = cregno;
          s_d.hreq.wdata = {(csize == ARC_SIZE_64) ? s_q.data1 : 32'h0000_0000, s_q.data0};
          s_d.st = ARC_XWAIT;
        end else begin
          // R13: increment applies without transfer too
          if (cinc) s_d.cmd[15:0] = cregno + 16'h0001;
          s_d.st = cpexec ? ARC_EXEC : ARC_IDLE;
          s_d.busy = cpexec;
        end
      end
      ARC_XWAIT: begin
        if (hrsp_i.ack) begin
          if (hrsp_i.err) begin
            if (s_d.err == ARC_ERR_NONE) s_d.err = ARC_ERR_EXCEPT;
            s_d.busy = 1'b0;
            s_d.st = ARC_IDLE;
          end else begin
            if (!cwrite) begin
              // R17: only first argument words change, and only on reads
              // R11: size picks one or two words
              // R22: least-significant word into data0
              s_d.data0 = hrsp_i.rdata[31:0];
              if (csize == ARC_SIZE_64) s_d.data1 = hrsp_i.rdata[63:32];
            end
            // R12: increment after a successful access
            if (cinc) s_d.cmd[15:0] = cregno + 16'h0001;
            s_d.st = cpexec ? ARC_EXEC : ARC_IDLE;
            s_d.busy = cpexec;
          end
        end
      end
      ARC_EXEC: begin
        // R14: program buffer started exactly once
        s_d.exec = 1'b1;
        s_d.st = ARC_EWAIT;
      end
      ARC_EWAIT: begin
        if (exec_done_i) begin
          // R25: success leaves the error field alone
          if (exec_err_i && s_d.err == ARC_ERR_NONE) s_d.err = ARC_ERR_EXCEPT;
          s_d.busy = 1'b0;
          s_d.st = ARC_IDLE;
        end
      end
      default: s_d.st = ARC_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // A pending error blocks new commands, so no command runs after a failure.
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign hreq_o = s_q.hreq;
  assign exec_req_o = s_q.exec;

  // ==========================================================================
  // Checks
  sequence seq_xfer_done;
    s_q.st == ARC_XWAIT && hrsp_i.ack && !hrsp_i.err;
  endsequence

  sequence seq_xfer_start;
    s_q.st == ARC_XFER && cxfer && ctype == ARC_TYPE_REG && !s_q.cmd[ARC_ZERO_BIT] &&
      !(cpexec && PROGBUF_WORDS == 16'h0000) && s_q.err == ARC_ERR_NONE && !cmd_wr;
  endsequence

  chk_busy_error: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    (acc && wb_we_i && wb_adr_i == ARC_ADR_CMD && s_q.busy) |=> s_q.err == ARC_ERR_BUSY)
    else $error("busy write did not flag busy error");

  chk_type_reject: assert property (@(posedge clk_i) disable iff (rst_i) // R21
    (s_q.st == ARC_XFER && ctype != ARC_TYPE_REG && s_q.err == ARC_ERR_NONE && !cmd_wr)
    |=> s_q.err == ARC_ERR_NOTSUP && !s_q.busy)
    else $error("bad command type not rejected");

  chk_xfer_issue: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (s_q.st == ARC_XFER && fail == ARC_ERR_NONE && cxfer) |=> s_q.hreq.req)
    else $error("valid transfer not issued");

  chk_missing_reg: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (seq_xfer_start and (csize == ARC_SIZE_64 && s_q.halted && cregno <= ARC_CSR_LAST))
    |=> s_q.err == ARC_ERR_EXCEPT && !s_q.busy && !s_q.hreq.req)
    else $error("missing register not reported as exception");

  chk_size_wide: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (seq_xfer_start and (csize == ARC_SIZE_128))
    |=> s_q.err == ARC_ERR_EXCEPT && !s_q.hreq.req)
    else $error("oversized access not failed");

  chk_run_refuse: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (seq_xfer_start and (csize == ARC_SIZE_64 && !s_q.halted))
    |=> s_q.err == ARC_ERR_NOTSUP && !s_q.hreq.req)
    else $error("access to running hart not refused");

  chk_no_xfer: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (s_q.st == ARC_XFER && !cxfer) |=> !s_q.hreq.req)
    else $error("register port used without transfer");

  chk_exec_after: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    (seq_xfer_done and cpexec) |=> ##1 s_q.exec)
    else $error("program buffer not started after transfer");

  chk_fail_skips: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (s_q.st == ARC_XFER && fail != ARC_ERR_NONE) |=> !s_q.hreq.req ##1 !s_q.exec)
    else $error("step ran after failure");

  chk_read_data: assert property (@(posedge clk_i) disable iff (rst_i) // R22
    (seq_xfer_done and !cwrite) |=> s_q.data0 == $past(hrsp_i.rdata[31:0]))
    else $error("read result not in data0");

  chk_write_keep: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    (seq_xfer_done and cwrite) |=> $stable(s_q.data0) && $stable(s_q.data1))
    else $error("write changed data words");

  chk_incr_regno: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (seq_xfer_done and cinc) |=> s_q.cmd[15:0] == $past(cregno) + 16'h0001)
    else $error("regno not incremented");

  chk_exec_once: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    s_q.exec |=> !s_q.exec)
    else $error("program buffer started twice");

  chk_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R24
    (s_q.st != ARC_IDLE) |-> s_q.busy)
    else $error("busy low during command");

endmodule

/* File: testbench/arc_hart_model.sv */
// Behavioural hart: general registers and a program-buffer runner.
`timescale 1ns/1ps
module arc_hart_model
  import arc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire arc_hreq_t hreq_i,
  input wire logic exec_req_i,
  input wire logic [3:0] delay_i,
  input wire logic exec_fail_i,
  output arc_hrsp_t hrsp_o,
  output logic exec_done_o,
  output logic exec_err_o,
  output logic [7:0] exec_cnt_o
);
  logic [63:0] gpr_q [32];
  logic [3:0] wait_q;
  logic [3:0] ewait_q;
  logic busy_q;
  always_ff @(posedge clk_i) begin
    hrsp_o.ack <= 1'b0;
    hrsp_o.err <= 1'b0;
    exec_done_o <= 1'b0;
    exec_err_o <= ~exec_fail_i;
    // Read data is not held once the answer is gone.
    hrsp_o.rdata <= ~hrsp_o.rdata;
    if (rst_i) begin
      busy_q <= 1'b0;
      ewait_q <= 4'h0;
      exec_cnt_o <= 8'h00;
    end else begin
      if (hreq_i.req) begin
        busy_q <= 1'b1;
        wait_q <= delay_i;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        hrsp_o.ack <= 1'b1;
        hrsp_o.rdata <= gpr_q[hreq_i.regno[4:0]];
        if (hreq_i.we) begin
          gpr_q[hreq_i.regno[4:0]] <= hreq_i.wdata;
        end
      end
      if (exec_req_i) begin
        ewait_q <= 4'h3;
        exec_cnt_o <= exec_cnt_o + 8'h01;
      end else if (ewait_q != 4'h0) begin
        ewait_q <= ewait_q - 4'h1;
        exec_done_o <= (ewait_q == 4'h1);
        exec_err_o <= exec_fail_i;
      end
    end
  end
endmodule

/* File: testbench/tb_abstract_register_access_cmd.sv */
// Self-checking bench for the register-access command engine.
`timescale 1ns/1ps
module tb_abstract_register_access_cmd
  import arc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic halted = 1'b1;
  logic [3:0] delay = 4'h1;
  logic efail = 1'b0;
  logic [7:0] ecnt;
  logic edone;
  logic eerr;
  logic ereq;
  arc_hreq_t hreq;
  arc_hrsp_t hrsp;
  int failures = 0;
  int n_compared = 0;
  always #2 clk_i = ~clk_i;
  arc_top arc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .hart_halted_i(halted), .hreq_o(hreq), .hrsp_i(hrsp),
    .exec_req_o(ereq), .exec_done_i(edone), .exec_err_i(eerr));
  arc_hart_model arc_hart_model_i (.clk_i(clk_i), .rst_i(rst_i), .hreq_i(hreq),
    .exec_req_i(ereq), .delay_i(delay), .exec_fail_i(efail), .hrsp_o(hrsp),
    .exec_done_o(edone), .exec_err_o(eerr), .exec_cnt_o(ecnt));
  // ==========================================================================
  // Bus and check helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, e, q);
  endtask
  function automatic logic [31:0] mk(input logic [2:0] sz, input logic inc, input logic px,
                                     input logic xf, input logic w, input logic [15:0] r);
    return {ARC_TYPE_REG, 1'b0, sz, inc, px, xf, w, r};
  endfunction
  // Issues a command, waits for idle, checks and clears the error field.
  task automatic run(input logic [31:0] c, input logic [2:0] e);
    logic [31:0] st;
    wr(ARC_ADR_CMD, c);
    for (int i = 0; i < 60; i++) begin
      wb(1'b0, ARC_ADR_STATUS, 32'h0, st);
      if (st[ARC_ST_BUSY_BIT] === 1'b0) break;
    end
    check("busy", 32'h0, {31'h0, st[ARC_ST_BUSY_BIT]});
    check("error", {29'h0, e}, {29'h0, st[10:8]});
    wr(ARC_ADR_STATUS, 32'h0000_0700);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_xfer();
    wr(ARC_ADR_DATA0, 32'h1234_5678);
    wr(ARC_ADR_DATA0 + 8'h04, 32'h9abc_def0);
    wr(ARC_ADR_DATA0 + 8'h08, 32'h5a5a_5a5a);
    run(mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b1, 16'h1005), ARC_ERR_NONE);
    wr(ARC_ADR_DATA0, 32'h0);
    wr(ARC_ADR_DATA0 + 8'h04, 32'h0);
    run(mk(ARC_SIZE_64, 1'b1, 1'b0, 1'b1, 1'b0, 16'h1005), ARC_ERR_NONE);
    rd_chk("data0", ARC_ADR_DATA0, 32'h1234_5678);
    rd_chk("data1", ARC_ADR_DATA0 + 8'h04, 32'h9abc_def0);
    rd_chk("data2", ARC_ADR_DATA0 + 8'h08, 32'h5a5a_5a5a);
    rd_chk("regno", ARC_ADR_CMD, mk(ARC_SIZE_64, 1'b1, 1'b0, 1'b1, 1'b0, 16'h1006));
    wr(ARC_ADR_DATA0 + 8'h04, 32'h5a5a_5a5a);
    run(mk(ARC_SIZE_32, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005), ARC_ERR_NONE);
    rd_chk("data1 narrow", ARC_ADR_DATA0 + 8'h04, 32'h5a5a_5a5a);
    $display("t_xfer done");
  endtask
  task automatic t_refuse();
    logic [31:0] c [6];
    logic [2:0] e [6];
    logic [7:0] n0;
    c = '{32'h0102_1005, 32'h0082_1005, mk(ARC_SIZE_128, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005),
          mk(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005),
          mk(ARC_SIZE_64, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0300),
          mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1020)};
    e = '{ARC_ERR_NOTSUP, ARC_ERR_NOTSUP, ARC_ERR_EXCEPT, ARC_ERR_NOTSUP, ARC_ERR_EXCEPT,
          ARC_ERR_EXCEPT};
    n0 = ecnt;
    wr(ARC_ADR_DATA0, 32'hc3c3_c3c3);
    for (int i = 0; i < 6; i++) begin
      run(c[i], e[i]);
    end
    check("exec skipped", {24'h0, n0}, {24'h0, ecnt});
    rd_chk("data0 kept", ARC_ADR_DATA0, 32'hc3c3_c3c3);
    wr(ARC_ADR_CMD, 32'h0102_1005);
    run(mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005), ARC_ERR_NOTSUP);
    rd_chk("data0 ignored", ARC_ADR_DATA0, 32'hc3c3_c3c3);
    $display("t_refuse done");
  endtask
  task automatic t_busy();
    delay <= 4'hc;
    wr(ARC_ADR_CMD, mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005));
    run(mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1001), ARC_ERR_BUSY);
    rd_chk("data0 busy", ARC_ADR_DATA0, 32'h1234_5678);
    delay <= 4'h1;
    $display("t_busy done");
  endtask
  task automatic t_exec();
    logic [7:0] n0;
    n0 = ecnt;
    run(mk(3'h7, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1007), ARC_ERR_NONE);
    check("exec once", {24'h0, n0 + 8'h01}, {24'h0, ecnt});
    rd_chk("inc no xfer", ARC_ADR_CMD, mk(3'h7, 1'b1, 1'b1, 1'b0, 1'b0, 16'h1008));
    efail <= 1'b1;
    run(mk(ARC_SIZE_64, 1'b0, 1'b1, 1'b1, 1'b0, 16'h1005), ARC_ERR_EXCEPT);
    efail <= 1'b0;
    halted <= 1'b0;
    repeat (4) @(posedge clk_i);
    run(mk(ARC_SIZE_64, 1'b0, 1'b0, 1'b1, 1'b0, 16'h1005), ARC_ERR_NOTSUP);
    halted <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(8'h40, 32'hffff_ffff);
    rd_chk("unmapped", 8'h40, 32'h0);
    $display("t_exec done");
  endtask
  // ==========================================================================
  // Sequence and verdict
  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_xfer();
    t_refuse();
    t_busy();
    t_exec();
    close_out();
  end
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule
